/* File: rtl/lds_cfg.svh */
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH

// serial slice geometry
`define LDS_SLICE_W      7
`define LDS_DATA_LANES   4
`define LDS_WORD_W       28
`define LDS_COLOUR_W     24

// forwarded clock lane pattern, sent msb first, one slice per pixel
`define LDS_CLK_PATTERN  7'h63

// lane map: entry k (5 bits) is the input bit sent on lane k/7, slot k%7;
// slot 6 leaves first. entry 27 is leftmost.
`define LDS_LANE_MAP { \
    5'h1B, 5'h17, 5'h16, 5'h0F, 5'h0E, 5'h07, 5'h06, \
    5'h1A, 5'h19, 5'h18, 5'h15, 5'h14, 5'h13, 5'h12, \
    5'h11, 5'h10, 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h09, \
    5'h08, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00 }
`define LDS_MAP_IDX_W    5

// bit clocks without a capture edge before the link counts as idle
`define LDS_IDLE_LIMIT   4'hE
`define LDS_IDLE_CNT_W   4

// frame counter width in the system domain
`define LDS_FRAME_CNT_W  16

`endif

/* File: rtl/lds_pkg.sv */
`default_nettype none

package lds_pkg;

    // one captured pixel word, 28 bits, colour in the low 24
    typedef struct packed {
        logic        spare;
        logic        pixel_valid;
        logic        frame_sync;
        logic        line_sync;
        logic [23:0] colour;
    } lds_pixel_t;

    // serial outputs of the five lanes
    typedef struct packed {
        logic       forwarded_lane_clock;
        logic [3:0] data;
    } lds_lanes_t;

    // link activity state in the bit-clock domain
    typedef enum logic [1:0] {
        LDS_ST_IDLE = 2'b01,
        LDS_ST_RUN  = 2'b10
    } lds_state_t;

endpackage : lds_pkg

`default_nettype wire

/* File: rtl/lds_sync.sv */
`default_nettype none

module lds_sync #(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // level from another domain
    input  wire logic [W-1:0] i_async,
    // synchronised level
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // two flops; the first is read by the second only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule : lds_sync

`default_nettype wire

/* File: rtl/lds_lane.sv */
`default_nettype none
`include "lds_cfg.svh"

module lds_lane (
    // bit clock and clear
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    // parallel load
    input  wire logic                    i_load,
    input  wire logic [`LDS_SLICE_W-1:0] i_slice,
    // serial output, registered
    output logic                         o_serial
);

    logic [`LDS_SLICE_W-1:0] shreg;

    // load puts slot 6 straight on the pin, the rest follows one per clock
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shreg    <= '0;
            o_serial <= 1'b0;
        end else if (i_load) begin
            shreg    <= {i_slice[`LDS_SLICE_W-2:0], 1'b0};
            o_serial <= i_slice[`LDS_SLICE_W-1];
        end else begin
            shreg    <= {shreg[`LDS_SLICE_W-2:0], 1'b0};
            o_serial <= shreg[`LDS_SLICE_W-1];
        end
    end

endmodule : lds_lane

`default_nettype wire

/* File: rtl/lds_serializer.sv */
`default_nettype none
`include "lds_cfg.svh"

module lds_serializer (
    // system clock domain
    input  wire logic               i_clk_sys,
    input  wire logic               i_arst_n,
    // synthesized bit clock, seven times the pixel clock
    input  wire logic               i_clk_bit,
    // video port pins
    input  wire logic               i_pixel_clock_in,
    input  wire lds_pkg::lds_pixel_t i_pixel,
    input  wire logic               i_capture_edge_select,
    input  wire logic               i_shutdown_clear_n,
    // serial lanes and driver enable, bit-clock domain
    output lds_pkg::lds_lanes_t     o_lanes,
    output logic                    o_driver_en,
    // status, system domain
    output logic                    o_link_active,
    output logic [`LDS_FRAME_CNT_W-1:0] o_frame_count
);

    localparam int SLICE_W = `LDS_SLICE_W;
    localparam int LANES   = `LDS_DATA_LANES;
    localparam int WORD_W  = `LDS_WORD_W;
    localparam int IDX_W   = `LDS_MAP_IDX_W;

    localparam logic [WORD_W*IDX_W-1:0] LANE_MAP    = `LDS_LANE_MAP;
    localparam logic [SLICE_W-1:0]      CLK_PATTERN = `LDS_CLK_PATTERN;

    // ------------------------------------------------------------------
    // bit-clock domain reset
    // ------------------------------------------------------------------
    logic       bit_clr_n;
    logic [1:0] bit_rst_pipe;
    logic       bit_rst_n;

    // shutdown clears the lane logic asynchronously, like a reset
    assign bit_clr_n = i_arst_n & i_shutdown_clear_n;
    assign bit_rst_n = bit_rst_pipe[1];

    // release is synchronised so no lane flop leaves reset half a cycle early
    always_ff @(posedge i_clk_bit or negedge bit_clr_n) begin
        if (!bit_clr_n) begin
            bit_rst_pipe <= 2'b00;
        end else begin
            bit_rst_pipe <= {bit_rst_pipe[0], 1'b1};
        end
    end

    // ------------------------------------------------------------------
    // pins into the bit-clock domain
    // ------------------------------------------------------------------
    lds_pkg::lds_pixel_t pix_sync;
    logic                pclk_sync;
    logic                edge_sel_sync;
    logic                pclk_prev;
    lds_pkg::lds_pixel_t pix_prev;

    // clock, data and select share one latency so data stays aligned
    lds_sync #(
        .W(WORD_W + 2)
    ) u_pin_sync (
        .i_clk   (i_clk_bit),
        .i_rst_n (bit_rst_n),
        .i_async ({i_pixel, i_pixel_clock_in, i_capture_edge_select}),
        .o_sync  ({pix_sync, pclk_sync, edge_sel_sync})
    );

    // one more stage of clock and data for edge detection
    always_ff @(posedge i_clk_bit or negedge bit_rst_n) begin
        if (!bit_rst_n) begin
            pclk_prev <= 1'b0;
            pix_prev  <= '0;
        end else begin
            pclk_prev <= pclk_sync;
            pix_prev  <= pix_sync;
        end
    end

    // ------------------------------------------------------------------
    // capture edge selection
    // ------------------------------------------------------------------
    logic pclk_rise;
    logic pclk_fall;
    logic capture;

    assign pclk_rise = pclk_sync & ~pclk_prev;
    assign pclk_fall = ~pclk_sync & pclk_prev;
    // changing the select mid-stream may drop or double one word; the board holds it fixed
    // high selects rising, low (the board strap) selects falling
    assign capture   = edge_sel_sync ? pclk_rise : pclk_fall;

    // ------------------------------------------------------------------
    // word capture
    // ------------------------------------------------------------------
    lds_pkg::lds_pixel_t word;
    logic                load;

    // the sample taken before the edge is the one that met the edge
    always_ff @(posedge i_clk_bit or negedge bit_rst_n) begin
        if (!bit_rst_n) begin
            word <= '0;
            load <= 1'b0;
        end else begin
            load <= capture;
            if (capture) begin
                word <= pix_prev; // all 28 bits in one go
            end
        end
    end

    // ------------------------------------------------------------------
    // lane mapping
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] word_bits;
    logic [WORD_W-1:0] lane_bits;

    // flatten the struct so the map can index any of the 28 bits
    assign word_bits = word;

    // fixed map; lane 3 gets the two top bits of each colour
    for (genvar k = 0; k < WORD_W; k++) begin : g_map
        wire [IDX_W-1:0] src = LANE_MAP[k*IDX_W +: IDX_W];
        assign lane_bits[k] = word_bits[src]; // bit for bit, nothing altered
    end

    // ------------------------------------------------------------------
    // data lanes and forwarded clock lane
    // ------------------------------------------------------------------
    logic [LANES-1:0] data_serial;
    logic             clk_serial;

    // one 7-bit register per data lane, reloaded on every captured edge
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        lds_lane u_lane (
            .i_clk    (i_clk_bit),
            .i_rst_n  (bit_rst_n),
            .i_load   (load), // one slice per pixel, no gap between words
            .i_slice  (lane_bits[l*SLICE_W +: SLICE_W]),
            .o_serial (data_serial[l])
        );
    end

    // clock lane loads its pattern on the same edge as the data
    lds_lane u_clk_lane (
        .i_clk    (i_clk_bit),
        .i_rst_n  (bit_rst_n),
        .i_load   (load),
        .i_slice  (CLK_PATTERN),
        .o_serial (clk_serial)
    );

    // five differential pairs leave the block
    assign o_lanes.data                 = data_serial;
    assign o_lanes.forwarded_lane_clock = clk_serial;

    // ------------------------------------------------------------------
    // link activity and driver enable
    // ------------------------------------------------------------------
    lds_pkg::lds_state_t         state;
    lds_pkg::lds_state_t         next_state;
    logic [`LDS_IDLE_CNT_W-1:0]  idle_cnt;
    logic [`LDS_IDLE_CNT_W-1:0]  next_idle_cnt;
    logic                        idle_timeout;
    logic                        running;

    // a 10 MHz pixel clock gives 7 bit clocks per edge; 14 means it stopped
    assign idle_timeout  = (idle_cnt == `LDS_IDLE_LIMIT);
    assign next_idle_cnt = capture      ? '0 :
                           idle_timeout ? idle_cnt :
                           idle_cnt + 1'b1;

    // run once a capture is seen, idle again after two missed pixel periods
    always_comb begin
        next_state = state;
        unique case (state)
            lds_pkg::LDS_ST_IDLE: begin
                if (capture) begin
                    next_state = lds_pkg::LDS_ST_RUN;
                end
            end
            lds_pkg::LDS_ST_RUN: begin
                if (idle_timeout) begin
                    next_state = lds_pkg::LDS_ST_IDLE;
                end
            end
            default: begin
                next_state = lds_pkg::LDS_ST_IDLE;
            end
        endcase
    end

    // drivers come on only once out of shutdown and reset
    always_ff @(posedge i_clk_bit or negedge bit_rst_n) begin
        if (!bit_rst_n) begin
            state       <= lds_pkg::LDS_ST_IDLE;
            idle_cnt    <= '0;
            o_driver_en <= 1'b0;
        end else begin
            state       <= next_state;
            idle_cnt    <= next_idle_cnt;
            o_driver_en <= 1'b1;
        end
    end

    // running leaves for the system domain straight from a flop, so a
    // decode glitch can never be caught by the synchroniser
    always_ff @(posedge i_clk_bit or negedge bit_rst_n) begin
        if (!bit_rst_n) begin
            running <= 1'b0;
        end else begin
            running <= (next_state == lds_pkg::LDS_ST_RUN);
        end
    end

    // frame start event as a toggle so the slow domain misses none spaced a system clock or more apart
    // limitation: two frame starts under one system clock apart can both be lost, as the toggle returns to its level
    logic frame_prev;
    logic frame_tog;

    always_ff @(posedge i_clk_bit or negedge bit_rst_n) begin
        if (!bit_rst_n) begin
            frame_prev <= 1'b0;
            frame_tog  <= 1'b0;
        end else if (load) begin
            frame_prev <= word.frame_sync;
            if (word.frame_sync && !frame_prev) begin
                frame_tog <= ~frame_tog;
            end
        end
    end

    // ------------------------------------------------------------------
    // system domain status
    // ------------------------------------------------------------------
    logic shdn_n_sys;
    logic running_sys;
    logic frame_tog_sys;
    logic frame_tog_seen;
    logic frame_event;

    lds_sync #(
        .W(3)
    ) u_sys_sync (
        .i_clk   (i_clk_sys),
        .i_rst_n (i_arst_n),
        .i_async ({i_shutdown_clear_n, running, frame_tog}),
        .o_sync  ({shdn_n_sys, running_sys, frame_tog_sys})
    );

    // one system clock of event per toggle seen
    assign frame_event = frame_tog_sys ^ frame_tog_seen;

    // toggle memory follows even in shutdown, so release brings no stale event
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_tog_seen <= 1'b0;
        end else begin
            frame_tog_seen <= frame_tog_sys;
        end
    end

    // link status drops while shut down
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_link_active <= 1'b0;
        end else begin
            o_link_active <= running_sys & shdn_n_sys;
        end
    end

    // frame count clears while shut down; the toggle memory and the system synchroniser keep running
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_frame_count <= '0;
        end else if (!shdn_n_sys) begin
            o_frame_count <= '0;
        end else if (frame_event) begin
            o_frame_count <= o_frame_count + 1'b1;
        end
    end

endmodule : lds_serializer

`default_nettype wire

/* File: sim/lds_serializer_properties.sv */
`default_nettype none
`include "lds_cfg.svh"

module lds_serializer_props (
    // clocks and resets
    input wire logic                          i_clk_sys,
    input wire logic                          i_arst_n,
    input wire logic                          i_clk_bit,
    input wire logic                          i_shutdown_clear_n,
    // lanes and status
    input wire lds_pkg::lds_lanes_t           o_lanes,
    input wire logic                          o_driver_en,
    input wire logic                          o_link_active,
    input wire logic [`LDS_FRAME_CNT_W-1:0]   o_frame_count
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] fwd_hist;
    logic [7:0] since;
    wire logic  fwd      = o_lanes.forwarded_lane_clock;
    // only the mid-slice rise, after one high and three low bits, marks a period;
    // the first slice after idle also rises at its start, which is no period mark
    wire logic  fwd_rise = fwd & (fwd_hist == 4'h8);

    // bit clocks since the period mark; saturates so idle gaps stay large
    always_ff @(posedge i_clk_bit or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fwd_hist <= 4'h0;
            since    <= 8'hFF;
        end else begin
            fwd_hist <= {fwd_hist[2:0], fwd};
            since <= fwd_rise ? 8'h00 : ((since == 8'hFF) ? since : since + 8'h01);
        end
    end

    pix_period_a: assert property (@(posedge i_clk_bit) disable iff (!i_arst_n)
        fwd_rise && since < 8'h14 |-> since == 8'h06)
        else $error("clock lane period is not seven bit clocks");
    clk_low_a: assert property (@(posedge i_clk_bit) disable iff (!i_arst_n)
        $fell(fwd) && o_driver_en |-> !fwd [*3])
        else $error("clock lane low phase too short");
    clk_high_a: assert property (@(posedge i_clk_bit) disable iff (!i_arst_n)
        $rose(fwd) && o_driver_en |=> fwd || !o_driver_en)
        else $error("clock lane high phase too short");
    drv_off_a: assert property (@(posedge i_clk_bit) disable iff (!i_arst_n)
        !i_shutdown_clear_n |-> !o_driver_en)
        else $error("drivers on during shutdown");
    lanes_idle_a: assert property (@(posedge i_clk_bit) disable iff (!i_arst_n)
        !o_driver_en |-> o_lanes == '0)
        else $error("lanes active with drivers off");
    en_rise_a: assert property (@(posedge i_clk_bit) disable iff (!i_arst_n)
        $rose(i_shutdown_clear_n) |-> ##[1:4] o_driver_en)
        else $error("drivers not enabled after shutdown release");
    stat_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !i_shutdown_clear_n [*5] |-> o_frame_count == '0 && !o_link_active)
        else $error("status not cleared by shutdown");
    frame_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_frame_count != $past(o_frame_count)
        |-> o_frame_count == $past(o_frame_count) + 1'b1 || o_frame_count == '0)
        else $error("frame count jumped");

    // main scenarios
    cover property (@(posedge i_clk_bit) fwd_rise && since == 8'h06);
    cover property (@(posedge i_clk_sys) $rose(o_link_active));
    cover property (@(posedge i_clk_bit) $fell(o_driver_en));

endmodule : lds_serializer_props

bind lds_serializer lds_serializer_props u_props (
    .i_clk_sys          (i_clk_sys),
    .i_arst_n           (i_arst_n),
    .i_clk_bit          (i_clk_bit),
    .i_shutdown_clear_n (i_shutdown_clear_n),
    .o_lanes            (o_lanes),
    .o_driver_en        (o_driver_en),
    .o_link_active      (o_link_active),
    .o_frame_count      (o_frame_count)
);

`default_nettype wire

/* File: sim/lds_panel_rx.sv */
`default_nettype none
`include "lds_cfg.svh"

module lds_panel_rx (
    // lanes from the transmitter
    input  wire logic                i_clk_bit,
    input  wire lds_pkg::lds_lanes_t i_lanes,
    input  wire logic                i_driver_en,
    // recovered word, valid for one bit clock
    output lds_pkg::lds_pixel_t      o_word,
    output logic                     o_word_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [139:0] MAP = `LDS_LANE_MAP;
    logic [6:0]  sh [0:4];
    logic [27:0] word;
    // a pair with its driver off reads as 0, so no pattern can be seen
    wire logic [4:0] lane_v = i_driver_en ? 5'(i_lanes) : 5'h00;

    // slot 6 is the oldest bit of each shifted slice
    always @(posedge i_clk_bit) begin
        for (int l = 0; l < 5; l++) begin
            sh[l] <= {sh[l][5:0], lane_v[l]};
        end
        o_word_valid <= (sh[4] == `LDS_CLK_PATTERN);
        o_word       <= word;
    end

    // undo the fixed lane map, colour msbs come back from the fourth lane
    always_comb begin
        word = '0;
        for (int k = 0; k < 28; k++) begin
            word[MAP[5*k +: 5]] = sh[k / 7][k % 7];
        end
    end

endmodule : lds_panel_rx

`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
`include "lds_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         i_clk_sys, i_arst_n, i_clk_bit, i_pixel_clock_in;
    logic                         i_capture_edge_select, i_shutdown_clear_n;
    logic                         o_driver_en, o_link_active, rx_valid, rx_chk;
    lds_pkg::lds_pixel_t          i_pixel, rx_word;
    lds_pkg::lds_lanes_t          o_lanes;
    logic [`LDS_FRAME_CNT_W-1:0]  o_frame_count, exp_fc;
    lds_pkg::lds_pixel_t          exp_q[$];
    int                           n_mismatch, samples_checked, n_rx, n_per, n_sent, pcnt, cycles;

    lds_serializer dut (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clk_bit(i_clk_bit),
        .i_pixel_clock_in(i_pixel_clock_in), .i_pixel(i_pixel),
        .i_capture_edge_select(i_capture_edge_select),
        .i_shutdown_clear_n(i_shutdown_clear_n), .o_lanes(o_lanes),
        .o_driver_en(o_driver_en), .o_link_active(o_link_active),
        .o_frame_count(o_frame_count));
    lds_panel_rx u_rx (.i_clk_bit(i_clk_bit), .i_lanes(o_lanes), .i_driver_en(o_driver_en),
        .o_word(rx_word), .o_word_valid(rx_valid));

    // system clock 100 ns, bit clock 32 ns with an unrelated phase
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_clk_bit = 1'b0;
        #7;
        forever #16 i_clk_bit = ~i_clk_bit;
    end

    // every colour bit walks, inverted on odd words; frame edges 8 words apart
    function automatic lds_pkg::lds_pixel_t wd(input int i);
        logic [23:0] c;
        c = 24'h000001 << (i % 24);
        wd = {i[1], (i % 5) != 4, (i % 8) == 0, (i % 3) == 0, i[0] ? ~c : c};
    endfunction : wd

    task automatic chk_word(input lds_pkg::lds_pixel_t exp, input lds_pkg::lds_pixel_t got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR word expected %h seen %h", exp, got);
        end
    endtask : chk_word

    task automatic chk_num(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_num

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic present();
        i_pixel <= wd(n_sent);
        exp_q.push_back(wd(n_sent));
        n_sent++;
    endtask : present

    // pixel clock 4 bit clocks high, 3 low; data moves on the edge not captured
    // the design sees only the 7:1 bit-to-pixel ratio, never the absolute rate
    always @(posedge i_clk_bit) begin
        if (pcnt != 0 || n_per > 0) begin
            pcnt <= (pcnt == 6) ? 0 : pcnt + 1;
            if (pcnt == 0) begin
                n_per            <= n_per - 1;
                i_pixel_clock_in <= 1'b1;
                if (!i_capture_edge_select) present();
            end
            if (pcnt == 4) begin
                i_pixel_clock_in <= 1'b0;
                if (i_capture_edge_select && n_per > 0) present();
            end
        end
    end

    // words recovered at the panel side must come back in order
    always @(posedge i_clk_bit) begin
        // every word seen while rx_chk is set is counted, so a surplus word shows in the word count
        if (rx_valid && rx_chk) begin
            n_rx++;
            if (exp_q.size() > 0) begin
                chk_word(exp_q.pop_front(), rx_word);
            end
        end
    end

    task automatic wait_idle();
        int t;
        t = 0;
        while ((n_per > 0 || pcnt != 0) && t < 2000) begin
            @(posedge i_clk_bit);
            t++;
        end
        if (t >= 2000) begin
            n_mismatch++;
            $display("ERROR wait_idle expected idle seen busy");
        end
    endtask : wait_idle

    task automatic burst(input logic sel, input int n);
        @(posedge i_clk_bit);
        i_capture_edge_select <= sel;
        repeat (8) @(posedge i_clk_bit);
        exp_q.delete();
        n_rx   = 0;
        n_sent = 0;
        rx_chk = 1'b1;
        if (sel) present();
        n_per <= n;
        repeat (n * 4) @(posedge i_clk_bit);
        chk_num("link active", 16'h0001, {15'h0000, o_link_active});
        wait_idle();
        repeat (20) @(posedge i_clk_bit);
        chk_num("words", 16'(n), 16'(n_rx));
        exp_fc = exp_fc + 16'((n + 7) / 8);
        chk_num("frames", exp_fc, o_frame_count);
        repeat (10) @(posedge i_clk_sys);
        chk_num("link idle", 16'h0000, {15'h0000, o_link_active});
        rx_chk = 1'b0;
    endtask : burst

    task automatic shutdown_mid();
        n_per <= 12;
        repeat (60) @(posedge i_clk_bit);
        @(posedge i_clk_sys);
        i_shutdown_clear_n <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        chk_num("driver enable", 16'h0000, {15'h0000, o_driver_en});
        chk_num("lanes", 16'h0000, {11'h000, o_lanes});
        chk_num("frames", 16'h0000, o_frame_count);
        chk_num("link active", 16'h0000, {15'h0000, o_link_active});
        wait_idle();
        @(posedge i_clk_sys);
        i_shutdown_clear_n <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        chk_num("driver enable", 16'h0001, {15'h0000, o_driver_en});
        exp_fc = 16'h0000;
    endtask : shutdown_mid

    // a hang ends the run as a mismatch
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        i_arst_n = 1'b0;
        i_pixel = '0;
        i_pixel_clock_in = 1'b0;
        i_capture_edge_select = 1'b0;
        i_shutdown_clear_n = 1'b1;
        {n_mismatch, samples_checked, n_rx, n_per, n_sent, pcnt, cycles} = '0;
        rx_chk = 1'b0;
        exp_fc = 16'h0000;
        repeat (5) @(posedge i_clk_sys);
        chk_num("lanes in reset", 16'h0000, {11'h000, o_lanes});
        chk_num("frames in reset", 16'h0000, o_frame_count);
        @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        chk_num("driver enable", 16'h0001, {15'h0000, o_driver_en});
        burst(1'b0, 40);
        burst(1'b1, 40);
        shutdown_mid();
        burst(1'b0, 24);
        end_sim();
    end

endmodule : testbench

`default_nettype wire
